// File: common/tx_serdes_pkg.sv
// constants shared by the transmit serializer, its buffer and its chip spreader
// assumes a single 20 MHz reference clock and a byte-wide register space
package tx_serdes_pkg;
  // clock and chip timing
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned CHIP_NS = 1000;
  localparam int unsigned CHIP_CYC = (CHIP_NS * CLK_MHZ) / 1000;
  localparam logic [4:0] CHIP_DIV_LAST = 5'(CHIP_CYC - 1);
  localparam logic [5:0] CHIPS_64_LAST = 6'h3F;
  localparam logic [5:0] CHIPS_32_LAST = 6'h1F;
  // register addresses
  localparam logic [5:0] ADDR_TX_IRQ_EN = 6'h0D;
  localparam logic [5:0] ADDR_TX_EVENT_STATUS = 6'h0E;
  localparam logic [5:0] ADDR_TX_BYTE_HOLDING = 6'h0F;
  localparam logic [5:0] ADDR_TX_BIT_VALID_MASK = 6'h10;
  localparam logic [5:0] ADDR_CODE_LO = 6'h11;
  localparam logic [5:0] ADDR_CODE_HI = 6'h18;
  // status and enable bit positions
  localparam int BIT_UNDERFLOW = 3;
  localparam int BIT_OVERFLOW = 2;
  localparam int BIT_DONE = 1;
  localparam int BIT_EMPTY = 0;
  localparam logic [3:0] READ_CLEAR_MASK = 4'hE;
  // reset values
  localparam logic [3:0] RST_IRQ_EN = 4'h0;
  localparam logic [3:0] RST_STATUS = 4'h0;
  localparam logic [7:0] RST_HOLDING = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [63:0] RST_CODE = 64'h1E8B_6A3D_E0E9_B222;
  // serial command byte fields and pin order
  localparam int CMD_WRITE_BIT = 7;
  localparam int CMD_INC_BIT = 6;
  localparam int PIN_SCLK = 2;
  localparam int PIN_CS = 1;
  localparam int PIN_MOSI = 0;
  localparam logic [2:0] PIN_IDLE = 3'h2;
  // bit value sent during preamble bit times
  localparam logic PREAMBLE_BIT = 1'b1;
  // buffer shape: word is {mask, data}
  localparam int WORD_W = 16;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [1:0] {CODE_64 = 2'b00, CODE_32_LO = 2'b01,
    CODE_32_HI = 2'b10, CODE_32_BOTH = 2'b11} code_mode_type;
  typedef enum logic {SPI_CMD = 1'b0, SPI_DATA = 1'b1} spi_state_type;
endpackage

// File: common/tx_word_if.sv
// valid/ready word channel between serializer and its buffer
// assumes both ends on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface tx_word_if import tx_serdes_pkg::*; ();
  logic valid;
  logic ready;
  logic [WORD_W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// File: core/word_buffer.sv
// small first-in first-out buffer of {mask, data} words
// assumes one clock; either side may stall
`timescale 1ns/1ps
`default_nettype none
module word_buffer import tx_serdes_pkg::*; #(
  parameter int W = WORD_W,
  parameter int D = BUF_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  tx_word_if.snk fill,
  tx_word_if.src drain
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam logic [PW:0] FULL = (PW + 1)'(D);
  localparam logic [PW-1:0] LAST = PW'(D - 1);
  logic [W-1:0] mem [D]; // entries, flops
  logic [PW-1:0] wp; // write index
  logic [PW-1:0] rp; // read index
  logic [PW:0] cnt; // occupied entries
  logic push;
  logic pop;
  assign push = fill.valid & fill.ready;
  assign pop = drain.valid & drain.ready;
  // full and empty come straight from the count
  assign fill.ready = (cnt != FULL);
  assign drain.valid = (cnt != '0);
  assign drain.data = mem[rp];
  // storage, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp] <= fill.data;
    end
  end
  // pointers and count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == LAST) ? '0 : PW'(wp + 1'b1);
      end
      if (pop) begin
        rp <= (rp == LAST) ? '0 : PW'(rp + 1'b1);
      end
      if (push && !pop) begin
        cnt <= (PW + 1)'(cnt + 1'b1);
      end else if (pop && !push) begin
        cnt <= (PW + 1)'(cnt - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// File: core/chip_spreader.sv
// spreads each bit over the code chips, low chip first
// assumes bit_value is steady for a whole bit time; idle while run is low
`timescale 1ns/1ps
`default_nettype none
module chip_spreader import tx_serdes_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [63:0] code,
  input wire code_mode_type mode,
  input wire logic bit_value,
  output logic chip,
  output logic bit_end
);
  logic [4:0] div; // chip rate divider
  logic [5:0] idx; // chip within the bit
  logic half; // which 32-chip code when both are used
  logic chip_tick;
  logic chip_last;
  logic [5:0] sel;
  assign chip_tick = run & (div == CHIP_DIV_LAST);
  assign chip_last = (mode == CODE_64) ? (idx == CHIPS_64_LAST) : (idx == CHIPS_32_LAST);
  // pick the code bit for this chip
  always_comb begin
    unique case (mode)
      CODE_64: sel = idx;
      CODE_32_LO: sel = {1'b0, idx[4:0]};
      CODE_32_HI: sel = {1'b1, idx[4:0]};
      CODE_32_BOTH: sel = {half, idx[4:0]};
    endcase
  end
  // divider, chip counter and chip output; a zero bit sends the inverted code
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div <= '0;
      idx <= '0;
      half <= 1'b0;
      chip <= 1'b0;
      bit_end <= 1'b0;
    end else if (!run) begin
      div <= '0;
      idx <= '0;
      half <= 1'b0;
      chip <= 1'b0;
      bit_end <= 1'b0;
    end else begin
      div <= chip_tick ? '0 : 5'(div + 1'b1);
      bit_end <= chip_tick & chip_last;
      if (chip_tick) begin
        chip <= code[sel] ^ ~bit_value;
        idx <= chip_last ? '0 : 6'(idx + 1'b1);
        half <= chip_last ? ~half : half;
      end
    end
  end
  property p_chip_ascending;
    @(posedge ref_clk) disable iff (!rst_b)
      (chip_tick && !chip_last) |=> (!run || (idx == 6'($past(idx) + 1'b1)));
  endproperty
  a_chip_ascending: assert property (p_chip_ascending) else $error("chip order broken");
endmodule
`default_nettype wire

// File: core/tx_serdes.sv
// transmit serializer with status flags, serial host port and code register
// assumes tx_enable comes from the mode register elsewhere in the device
`timescale 1ns/1ps
`default_nettype none
module tx_serdes import tx_serdes_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic tx_enable,
  input wire code_mode_type code_mode,
  input wire logic spi_sclk,
  input wire logic spi_cs_b,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic tx_chip,
  output logic tx_preamble,
  output logic tx_irq
);
  // pin synchronisers, three stages each
  logic [2:0] pin_raw;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_f; // accepted pin levels
  // serial port state
  spi_state_type spi_state;
  logic [2:0] bit_cnt; // bits of the current byte
  logic [6:0] rx_sr; // incoming bits
  logic [7:0] miso_sr; // outgoing bits, top bit on the pin
  logic [5:0] addr; // current register address
  logic wr_mode; // command was a write
  logic inc_mode; // address steps after each byte
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;
  logic [7:0] byte_val;
  logic [5:0] rd_addr;
  logic rd_load;
  logic wr_strobe;
  logic rd_clear;
  // registers
  logic [3:0] irq_en; // interrupt enables
  logic [3:0] status; // sticky event flags
  logic [7:0] holding; // byte written by the host
  logic [7:0] valid_mask; // per-bit valid mask
  logic [63:0] code; // spreading code
  logic hold_full; // holding byte not yet moved on
  // serializer
  logic [7:0] sh_data;
  logic [7:0] sh_mask;
  logic active; // shifter holds valid bits
  logic sent_any; // a bit went out since enable
  logic bit_end; // end of a bit time
  logic bit_value;
  logic byte_end;
  logic take;
  logic load;
  logic push;
  logic wr_hold;
  logic ev_underflow;
  logic ev_overflow;
  logic ev_done;
  logic ev_empty;
  logic [3:0] events;
  logic [3:0] clr;
  logic [3:0] next_status;
  tx_word_if to_buf ();
  tx_word_if from_buf ();

  assign pin_raw = {spi_sclk, spi_cs_b, spi_mosi};
  // a pin change counts only once stages two and three agree
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        sync1[i] <= PIN_IDLE[i];
        sync2[i] <= PIN_IDLE[i];
        sync3[i] <= PIN_IDLE[i];
        pin_f[i] <= PIN_IDLE[i];
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          pin_f[i] <= sync3[i];
        end
      end
    end
  end

  // clock edges seen while selected
  assign sclk_rise = ~pin_f[PIN_CS] & (sync2[PIN_SCLK] == sync3[PIN_SCLK])
    & sync3[PIN_SCLK] & ~pin_f[PIN_SCLK];
  assign sclk_fall = ~pin_f[PIN_CS] & (sync2[PIN_SCLK] == sync3[PIN_SCLK])
    & ~sync3[PIN_SCLK] & pin_f[PIN_SCLK];
  assign byte_done = sclk_rise & (bit_cnt == 3'h7);
  assign byte_val = {rx_sr, pin_f[PIN_MOSI]};
  // read address: from the command byte, or the next one in a burst
  assign rd_addr = (spi_state == SPI_CMD) ? byte_val[5:0] : 6'(addr + {5'h00, inc_mode});
  assign rd_load = byte_done & ((spi_state == SPI_CMD) ? ~byte_val[CMD_WRITE_BIT] : ~wr_mode);
  assign wr_strobe = byte_done & (spi_state == SPI_DATA) & wr_mode;
  assign rd_clear = rd_load & (rd_addr == ADDR_TX_EVENT_STATUS);
  assign wr_hold = wr_strobe & (addr == ADDR_TX_BYTE_HOLDING);

  // register read mux; unmapped addresses read zero
  function automatic logic [7:0] reg_read(input logic [5:0] a);
    logic [2:0] k;
    k = 3'(a - ADDR_CODE_LO);
    reg_read = 8'h00;
    if (a == ADDR_TX_IRQ_EN) begin
      reg_read = {4'h0, irq_en};
    end else if (a == ADDR_TX_EVENT_STATUS) begin
      reg_read = {4'h0, status};
    end else if (a == ADDR_TX_BYTE_HOLDING) begin
      reg_read = holding;
    end else if (a == ADDR_TX_BIT_VALID_MASK) begin
      reg_read = valid_mask;
    end else if (a >= ADDR_CODE_LO && a <= ADDR_CODE_HI) begin
      reg_read = code[{k, 3'h0} +: 8];
    end
  endfunction

  // serial byte framing and command decode; deselect aborts the frame
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_state <= SPI_CMD;
      bit_cnt <= 3'h0;
      rx_sr <= 7'h00;
      addr <= 6'h00;
      wr_mode <= 1'b0;
      inc_mode <= 1'b0;
    end else if (pin_f[PIN_CS]) begin
      spi_state <= SPI_CMD;
      bit_cnt <= 3'h0;
    end else if (sclk_rise) begin
      rx_sr <= byte_val[6:0];
      bit_cnt <= 3'(bit_cnt + 1'b1);
      if (byte_done) begin
        unique case (spi_state)
          SPI_CMD: begin
            addr <= byte_val[5:0];
            wr_mode <= byte_val[CMD_WRITE_BIT];
            inc_mode <= byte_val[CMD_INC_BIT];
            spi_state <= SPI_DATA;
          end
          SPI_DATA: begin
            addr <= 6'(addr + {5'h00, inc_mode});
          end
        endcase
      end
    end
  end

  // read data out, loaded on the last rising edge of a byte, shifted on falling edges only inside a byte
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      miso_sr <= 8'h00;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= ~pin_f[PIN_CS];
      if (rd_load) begin
        miso_sr <= reg_read(rd_addr);
      end else if (sclk_fall && bit_cnt != 3'h0) begin
        miso_sr <= {miso_sr[6:0], 1'b0};
      end
    end
  end
  assign spi_miso = miso_sr[7];

  // host-writable registers; the status register takes no writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en <= RST_IRQ_EN;
      holding <= RST_HOLDING;
      valid_mask <= RST_MASK;
      code <= RST_CODE;
    end else if (wr_strobe) begin
      if (addr == ADDR_TX_IRQ_EN) begin
        irq_en <= byte_val[3:0];
      end else if (addr == ADDR_TX_BYTE_HOLDING) begin
        holding <= byte_val;
      end else if (addr == ADDR_TX_BIT_VALID_MASK) begin
        valid_mask <= byte_val;
      end else if (addr >= ADDR_CODE_LO && addr <= ADDR_CODE_HI) begin
        code[{3'(addr - ADDR_CODE_LO), 3'h0} +: 8] <= byte_val;
      end
    end
  end

  // holding stage feeds the buffer; a write in the move cycle wins
  assign to_buf.valid = hold_full;
  assign to_buf.data = {valid_mask, holding};
  assign push = hold_full & to_buf.ready;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_full <= 1'b0;
    end else if (wr_hold) begin
      hold_full <= 1'b1;
    end else if (push) begin
      hold_full <= 1'b0;
    end
  end

  word_buffer u_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .fill(to_buf),
    .drain(from_buf)
  );

  // shifter wants a word at a bit boundary when idle or on its last valid bit
  assign byte_end = active & (sh_mask[7:1] == 7'h00);
  assign take = bit_end & tx_enable & (~active | byte_end);
  assign from_buf.ready = take;
  assign load = take & from_buf.valid;
  assign bit_value = (active & sh_mask[0]) ? sh_data[0] : PREAMBLE_BIT;

  // shifter, low bit first; idle bit times send preamble
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_data <= 8'h00;
      sh_mask <= 8'h00;
      active <= 1'b0;
    end else if (!tx_enable) begin
      sh_data <= 8'h00;
      sh_mask <= 8'h00;
      active <= 1'b0;
    end else if (load) begin
      sh_data <= from_buf.data[7:0];
      sh_mask <= from_buf.data[15:8];
      active <= |from_buf.data[15:8];
    end else if (bit_end && active) begin
      sh_data <= {1'b0, sh_data[7:1]};
      sh_mask <= {1'b0, sh_mask[7:1]};
      active <= |sh_mask[7:1];
    end
  end

  // remembers that a bit went out since transmit mode began
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sent_any <= 1'b0;
    end else if (!tx_enable) begin
      sent_any <= 1'b0;
    end else if (bit_end && active) begin
      sent_any <= 1'b1;
    end
  end

  chip_spreader u_chip (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(tx_enable),
    .code(code),
    .mode(code_mode),
    .bit_value(bit_value),
    .chip(tx_chip),
    .bit_end(bit_end)
  );

  // events, independent of the enables
  assign ev_underflow = take & ~active & ~from_buf.valid & sent_any;
  assign ev_overflow = wr_hold & hold_full & ~push;
  assign ev_done = take & active & ~from_buf.valid & ~hold_full;
  assign ev_empty = push & ~wr_hold;
  assign events = {ev_underflow, ev_overflow, ev_done, ev_empty};
  assign clr = (rd_clear ? READ_CLEAR_MASK : 4'h0) | {3'h0, wr_hold};
  assign next_status = (status & ~clr) | events;

  // sticky flags; all held at zero outside transmit mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= RST_STATUS;
    end else if (!tx_enable) begin
      status <= RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  // line outputs and the gated interrupt
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_preamble <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      tx_preamble <= tx_enable & ~(active & sh_mask[0]);
      tx_irq <= |(status & irq_en);
    end
  end

  property p_underflow;
    @(posedge ref_clk) disable iff (!rst_b)
      (take && !active && !from_buf.valid && sent_any) |=> status[BIT_UNDERFLOW];
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow not flagged");
  property p_no_early_underflow;
    @(posedge ref_clk) disable iff (!rst_b)
      (!sent_any && !status[BIT_UNDERFLOW]) |=> !status[BIT_UNDERFLOW];
  endproperty
  a_no_early_underflow: assert property (p_no_early_underflow) else $error("early underflow");
  property p_overflow;
    @(posedge ref_clk) disable iff (!rst_b)
      (tx_enable && wr_hold && hold_full && !push) |=> status[BIT_OVERFLOW];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");
  property p_done;
    @(posedge ref_clk) disable iff (!rst_b)
      (take && byte_end && !from_buf.valid && !hold_full) |=> status[BIT_DONE] && sent_any;
  endproperty
  a_done: assert property (p_done) else $error("done not flagged");
  property p_read_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      (rd_clear && !ev_underflow && !ev_overflow && !ev_done) |=> (status[3:1] == 3'h0);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");
  property p_set_wins;
    @(posedge ref_clk) disable iff (!rst_b)
      (tx_enable && rd_clear && ev_overflow) |=> status[BIT_OVERFLOW];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
  property p_empty_set;
    @(posedge ref_clk) disable iff (!rst_b)
      (tx_enable && push && !wr_hold) |=> status[BIT_EMPTY] ##1 !hold_full || status[BIT_EMPTY];
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("empty not set");
  property p_empty_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_hold && !push) |=> !status[BIT_EMPTY] && hold_full;
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("empty not cleared");
  property p_off_zero;
    @(posedge ref_clk) disable iff (!rst_b)
      !tx_enable |=> (status == 4'h0) && !tx_preamble;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("status not zero when off");
  property p_irq_gate;
    @(posedge ref_clk) disable iff (!rst_b)
      ((status & irq_en) == 4'h0) |=> !tx_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ungated interrupt");
  property p_lsb_first;
    @(posedge ref_clk) disable iff (!rst_b)
      (tx_enable && bit_end && active && !load) |=> (sh_data == {1'b0, $past(sh_data[7:1])});
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("shift order wrong");
endmodule
`default_nettype wire

// File: dv/spi_host_model.sv
// host side of the serial register port: a mode 0 master sending whole byte frames
// assumes ref_clk is the device clock; each serial clock level lasts HALF cycles
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic ref_clk,
  output logic spi_sclk,
  output logic spi_cs_b,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  localparam int HALF = 8; // four times the shortest level the device accepts
  // idle: clock parked low, deselected
  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
  end
  // command byte, then n data bytes; byte i of wr and rd sits at bits 8*i+7:8*i
  task automatic frame(input logic [7:0] cmd, input int n, input logic [63:0] wr,
      output logic [63:0] rd);
    logic [7:0] tx;
    rd = '0;
    @(negedge ref_clk);
    spi_cs_b = 1'b0;
    for (int b = 0; b <= n; b++) begin
      tx = cmd;
      if (b > 0) begin
        tx = wr[8*b-8 +: 8];
      end
      for (int k = 7; k >= 0; k--) begin
        spi_mosi = tx[k];
        repeat (HALF) @(negedge ref_clk);
        // answer sampled just before the rising edge, long settled by then
        if (b > 0) begin
          rd[8*b-8+k] = spi_miso & spi_miso_oe;
        end
        spi_sclk = 1'b1;
        repeat (HALF) @(negedge ref_clk);
        spi_sclk = 1'b0;
      end
    end
    repeat (HALF) @(negedge ref_clk);
    spi_cs_b = 1'b1;
    // released data line shows the inverse, so a stale bit is never mistaken for data
    spi_mosi = ~spi_mosi;
    repeat (HALF) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// File: dv/dsss_tx_serializer_status_test.sv
// self-checking bench for the transmit serializer: registers, bit stream, flags
// assumes spi_host_model as the host; inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module dsss_tx_serializer_status_test import tx_serdes_pkg::*; ;
  localparam int BIT32 = 32 * CHIP_CYC; // cycles per bit with a 32-chip code
  logic ref_clk; // device clock
  logic rst_b; // async reset, active low
  logic tx_enable; // transmit mode
  code_mode_type code_mode; // code length choice
  logic spi_sclk, spi_cs_b, spi_mosi, spi_miso, spi_miso_oe; // serial port
  logic tx_chip, tx_preamble, tx_irq; // outputs under test
  int miscompares, cmp_count; // report counters
  tx_serdes DUT (.ref_clk(ref_clk), .rst_b(rst_b), .tx_enable(tx_enable),
    .code_mode(code_mode), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .tx_chip(tx_chip),
    .tx_preamble(tx_preamble), .tx_irq(tx_irq));
  spi_host_model host (.ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  // 50 ns period
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  // value compare
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // pin level compare
  task automatic check_pin(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // single register write
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    logic [63:0] r;
    host.frame({2'b10, a}, 1, {56'h0, d}, r);
  endtask
  // single register read and compare
  task automatic reg_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [63:0] r;
    host.frame({2'b00, a}, 1, 64'h0, r);
    check_val({8'h00, r[7:0]}, {8'h00, exp});
  endtask
  // reset values, code burst, code write and unmapped accesses
  task automatic test_regs;
    logic [63:0] r;
    reg_chk(ADDR_TX_EVENT_STATUS, 8'h00);
    reg_chk(ADDR_TX_BYTE_HOLDING, RST_HOLDING);
    reg_chk(ADDR_TX_BIT_VALID_MASK, RST_MASK);
    host.frame({2'b01, ADDR_CODE_LO}, 8, 64'h0, r);
    for (int i = 0; i < 4; i++) begin
      check_val(r[16*i +: 16], RST_CODE[16*i +: 16]);
    end
    reg_wr(ADDR_CODE_HI, 8'hC3);
    reg_chk(ADDR_CODE_HI, 8'hC3);
    reg_chk(6'h3F, 8'h00);
  endtask
  // mask 0x7E: preamble first, six data bits, top bit never sent
  // idle bit times also show preamble, so the data phase is found by its falling edge
  task automatic test_bit_order;
    logic [7:0] got;
    int ones, pre;
    got = 8'h00;
    pre = 0;
    tx_enable = 1'b1;
    reg_wr(ADDR_TX_EVENT_STATUS, 8'hFF);
    repeat (1500) @(negedge ref_clk);
    reg_chk(ADDR_TX_EVENT_STATUS, 8'h00);
    reg_wr(ADDR_TX_BIT_VALID_MASK, 8'h7E);
    reg_chk(ADDR_TX_BIT_VALID_MASK, 8'h7E);
    fork
      reg_wr(ADDR_TX_BYTE_HOLDING, 8'h5A);
      begin
        // bounded wait for the first data bit time (bit 1)
        for (int i = 0; i < 20000 && tx_preamble !== 1'b0; i++) @(negedge ref_clk);
        check_pin(tx_preamble, 1'b0);
        // the low code half has fewer ones than zeros: few ones means a plain code, data 1
        // chips trail the preamble flag by about one chip, hence the offset of 30
        for (int b = 1; b < 7; b++) begin
          ones = 0;
          for (int c = 0; c < BIT32; c++) begin
            if (b == 1 && (c == 30 || c == 50)) check_pin(tx_chip, RST_CODE[(c-30)/20]);
            if (tx_chip === 1'b1) ones++;
            if (tx_preamble === 1'b1) pre++;
            @(negedge ref_clk);
          end
          got[b] = (ones < BIT32 / 2);
        end
      end
    join
    check_val({8'h00, got}, 16'h005A);
    check_val(pre[15:0], 16'h0000);
    reg_chk(ADDR_TX_EVENT_STATUS, 8'h03);
    repeat (1400) @(negedge ref_clk);
    reg_chk(ADDR_TX_EVENT_STATUS, 8'h09);
  endtask
  // five back-to-back writes with 64-chip code, then a full drain
  task automatic test_overflow_drain;
    logic [63:0] r;
    code_mode = CODE_64;
    reg_wr(ADDR_TX_BIT_VALID_MASK, 8'h0F);
    host.frame({2'b10, ADDR_TX_BYTE_HOLDING}, 5, 64'h0000_00F1_E2D3_C4B5, r);
    host.frame({2'b00, ADDR_TX_EVENT_STATUS}, 1, 64'h0, r);
    // underflow may already be pending from the idle gap, so it is left out here
    check_val({13'h0, r[2:0]}, 16'h0004);
    repeat (24000) @(negedge ref_clk);
    reg_chk(ADDR_TX_EVENT_STATUS, 8'h0B);
    reg_chk(ADDR_TX_EVENT_STATUS, 8'h01);
  endtask
  // interrupt follows enabled flags only; leaving transmit mode zeroes status
  task automatic test_irq_disable;
    reg_wr(ADDR_TX_IRQ_EN, 8'h02);
    reg_chk(ADDR_TX_IRQ_EN, 8'h02);
    check_pin(tx_irq, 1'b0);
    reg_wr(ADDR_TX_IRQ_EN, 8'h09);
    repeat (4) @(negedge ref_clk);
    check_pin(tx_irq, 1'b1);
    tx_enable = 1'b0;
    repeat (4) @(negedge ref_clk);
    check_pin(tx_irq, 1'b0);
    reg_chk(ADDR_TX_EVENT_STATUS, 8'h00);
  endtask
  // verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    miscompares = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    tx_enable = 1'b0;
    code_mode = CODE_32_LO;
    repeat (10) @(negedge ref_clk);
    rst_b = 1'b1;
    test_regs();
    test_bit_order();
    test_overflow_drain();
    test_irq_disable();
    test_done();
  end
  // watchdog: about twice the expected run length
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
